// ### src/pmw_pkg.sv
// package for the power mode and wake control block
package pmw_pkg;
    // apb register byte offsets
    localparam logic [7:0] PMW_SCC_OFF = 8'h00;
    localparam logic [7:0] PMW_CMD_OFF = 8'h04;
    localparam logic [7:0] PMW_STAT_OFF = 8'h08;
    localparam logic [7:0] PMW_WAKE_OFF = 8'h0c;
    localparam logic [7:0] PMW_OSC_OFF = 8'h10;
    // clock control field layout and reset value
    localparam int PMW_CKS_LSB = 5;
    localparam int PMW_FHS_BIT = 3;
    localparam int PMW_FSS_BIT = 2;
    localparam int PMW_FHID_BIT = 1;
    localparam int PMW_FSID_BIT = 0;
    localparam logic [7:0] PMW_SCC_RST = 8'he0;
    localparam logic [2:0] PMW_CKS_SUB = 3'h7;
    // command register bits (write one to act)
    localparam int PMW_CMD_HALT = 0;
    localparam int PMW_CMD_CLRWDT = 1;
    // oscillator control bits
    localparam int PMW_OSC_IRCEN = 0;
    localparam int PMW_OSC_HXTEN = 1;
    localparam int PMW_OSC_WDTEN = 2;
    localparam logic [2:0] PMW_OSC_RST = 3'h4;
    // status register bit positions
    localparam int PMW_ST_PDF = 0;
    localparam int PMW_ST_TO = 1;
    localparam int PMW_ST_INT_FAST_OSC_STABLE = 2;
    localparam int PMW_ST_EXT_FAST_OSC_STABLE = 3;
    localparam int PMW_ST_SLOW = 4;
    localparam int PMW_ST_MODE = 5;
    // oscillator settle time, counted in pclk cycles
    localparam int PMW_OSC_SETTLE_NS = 2000;
    localparam int PMW_CLK_NS = 40;
    localparam int PMW_SETTLE_CYC = (PMW_OSC_SETTLE_NS + PMW_CLK_NS - 1)
        / PMW_CLK_NS;
    localparam int PMW_WDT_W = 18;
    localparam int PMW_PA_W = 8;
    localparam int PMW_DIV_W = 6;
    // operating modes, gray in list order run, sleep, idle0, idle1, idle2, wake
    typedef enum logic [2:0] {
        PMW_RUN = 3'h0,
        PMW_SLEEP = 3'h1,
        PMW_IDLE0 = 3'h3,
        PMW_IDLE1 = 3'h2,
        PMW_IDLE2 = 3'h6,
        PMW_WAKE = 3'h4
    } pmw_mode_t;
    // clock enables handed to the chip
    typedef struct packed {
        logic sys_clk_en;
        logic high_speed_clock_en;
        logic low_speed_clock_en;
        logic watchdog_base_clock_en;
        logic wdt_src_crystal;
    } pmw_clk_t;
    // wake response to the core
    typedef struct packed {
        logic cpu_run;
        logic full_reset;
        logic pc_sp_reset;
        logic irq_service;
    } pmw_wake_t;
endpackage

// ### src/pmw_ctrl.sv
// power mode, clock select and wake control with apb registers
// Contract
// - select 000..110 outside slow mode gives high-speed clock / 1..64.
// - leaving slow mode waits for the chosen fast oscillator stable flag.
// - halt with both idle enables 0 enters sleep, all clocks off.
// - watchdog base clock runs in low power modes when watchdog enabled.
// - halt with fast 0, slow 1 enters idle0, only slow clock runs.
// - halt with both idle enables 1 enters idle1, both clocks run.
// - halt with fast 1, slow 0 enters idle2, only fast clock runs.
// - entering low power changes no memory, register or port state.
// - entering low power clears the timeout flag.
// - entering low power clears watchdog counter; counts only if enabled.
// - wake on reset pin, enabled port a fall, interrupt, watchdog overflow.
// - reset pin wake does a full system reset.
// - watchdog wake sets timeout, resets only pc and stack pointer.
// - power down flag set by halt, cleared by power-up or clear watchdog.
// - each port a pin has its own wake enable; resume after halt.
// - disabled interrupt or full stack wake resumes after halt, stays pending.
// - enabled interrupt with stack room gets normal interrupt response.
// - interrupt already pending before halt is not a wake source.
// - select 111 switches system clock to low-speed clock, slow mode.
// - enabling a fast oscillator shows stable 0 then 1 when settled; here it settles only while high_speed_clock_en is set, so stays 0 in slow mode.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pmw_ctrl
    import pmw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_reset_pin_n,
    input wire logic [pmw_pkg::PMW_PA_W-1:0] port_a_in,
    input wire logic irq_req,
    input wire logic irq_enabled,
    input wire logic stack_full,
    output pmw_pkg::pmw_clk_t clk_ctl,
    output pmw_pkg::pmw_wake_t wake_ctl,
    output logic [pmw_pkg::PMW_DIV_W:0] sys_div_sel
);
    import pmw_pkg::*;

    logic [7:0] system_clock_control_r;
    logic [2:0] osc_ctl_r;
    logic [PMW_PA_W-1:0] port_a_wake_enable_r, pa_last_r;
    logic power_down_flag_r, timeout_flag_r;
    logic [PMW_WDT_W-1:0] wdt_cnt_r;
    logic irq_pend_at_halt_r, ext_rst_last_r;
    logic [11:0] irc_cnt_r, hxt_cnt_r;
    logic int_fast_osc_stable, ext_fast_osc_stable;
    pmw_mode_t mode_r, mode_nxt;
    logic wr, rd, halt_cmd, clrwdt_cmd;
    logic [2:0] sysclk_select;
    logic fast_ok, pa_fall, irq_wake, wdt_ovf, ext_rst_fall, any_wake;
    logic fast_osc_idle_enable, slow_osc_idle_enable, low_freq_source_select;
    logic in_lp;
    logic on_sub_r;
    // divider select that stands for the low-speed sub clock
    localparam logic [PMW_DIV_W:0] DIV_SUB_SEL = {1'b1, {PMW_DIV_W{1'b0}}};

    assign sysclk_select = system_clock_control_r[PMW_CKS_LSB+:3];
    assign fast_osc_idle_enable = system_clock_control_r[PMW_FHID_BIT];
    assign slow_osc_idle_enable = system_clock_control_r[PMW_FSID_BIT];
    assign low_freq_source_select = system_clock_control_r[PMW_FSS_BIT];

    // apb decode, zero wait state
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (paddr != PMW_SCC_OFF)
        & (paddr != PMW_CMD_OFF) & (paddr != PMW_STAT_OFF)
        & (paddr != PMW_WAKE_OFF) & (paddr != PMW_OSC_OFF);
    assign halt_cmd = wr & (paddr == PMW_CMD_OFF) & pwdata[PMW_CMD_HALT]
        & (mode_r == PMW_RUN);
    assign clrwdt_cmd = wr & (paddr == PMW_CMD_OFF) & pwdata[PMW_CMD_CLRWDT];
    assign in_lp = (mode_r != PMW_RUN) & (mode_r != PMW_WAKE);

    // control registers; port a enables per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_control_r <= PMW_SCC_RST;
            osc_ctl_r <= PMW_OSC_RST;
            port_a_wake_enable_r <= '0;
        end else if (wr) begin
            if (paddr == PMW_SCC_OFF)
                system_clock_control_r <= pwdata[7:0] & 8'hef;
            if (paddr == PMW_OSC_OFF)
                osc_ctl_r <= pwdata[2:0];
            if (paddr == PMW_WAKE_OFF)
                port_a_wake_enable_r <= pwdata[PMW_PA_W-1:0];
        end
    end

    // oscillator settle counters: flag 0 on enable, 1 after settle while the high-speed clock enable is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irc_cnt_r <= '0;
            hxt_cnt_r <= '0;
        end else begin
            if (!osc_ctl_r[PMW_OSC_IRCEN] || !clk_ctl.high_speed_clock_en)
                irc_cnt_r <= '0;
            else if (!int_fast_osc_stable)
                irc_cnt_r <= irc_cnt_r + 12'h001;
            if (!osc_ctl_r[PMW_OSC_HXTEN] || !clk_ctl.high_speed_clock_en)
                hxt_cnt_r <= '0;
            else if (!ext_fast_osc_stable)
                hxt_cnt_r <= hxt_cnt_r + 12'h001;
        end
    end
    assign int_fast_osc_stable = irc_cnt_r >= 12'(PMW_SETTLE_CYC);
    assign ext_fast_osc_stable = hxt_cnt_r >= 12'(PMW_SETTLE_CYC);
    // stable flag of the selected fast oscillator
    assign fast_ok = system_clock_control_r[PMW_FHS_BIT]
        ? ext_fast_osc_stable : int_fast_osc_stable;

    // wake sources
    assign pa_fall = |(pa_last_r & ~port_a_in & port_a_wake_enable_r);
    assign irq_wake = irq_req & ~irq_pend_at_halt_r;
    assign wdt_ovf = osc_ctl_r[PMW_OSC_WDTEN] & (&wdt_cnt_r);
    assign ext_rst_fall = ext_rst_last_r & ~external_reset_pin_n;
    assign any_wake = pa_fall | irq_wake | wdt_ovf | ext_rst_fall;

    // edge history and interrupt pending snapshot at halt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_last_r <= '1;
            ext_rst_last_r <= 1'b1;
            irq_pend_at_halt_r <= 1'b0;
        end else begin
            pa_last_r <= port_a_in;
            ext_rst_last_r <= external_reset_pin_n;
            if (halt_cmd)
                irq_pend_at_halt_r <= irq_req;
            else if (!irq_req)
                irq_pend_at_halt_r <= 1'b0;
        end
    end

    // mode decode on halt, wake on any source
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            PMW_RUN: begin
                if (halt_cmd) begin
                    unique case ({fast_osc_idle_enable, slow_osc_idle_enable})
                        2'b00: mode_nxt = PMW_SLEEP;
                        2'b01: mode_nxt = PMW_IDLE0;
                        2'b11: mode_nxt = PMW_IDLE1;
                        2'b10: mode_nxt = PMW_IDLE2;
                    endcase
                end
            end
            PMW_SLEEP, PMW_IDLE0, PMW_IDLE1, PMW_IDLE2: begin
                if (any_wake)
                    mode_nxt = PMW_WAKE;
            end
            PMW_WAKE: begin
                if (sysclk_select == PMW_CKS_SUB || fast_ok)
                    mode_nxt = PMW_RUN;
            end
            default: mode_nxt = PMW_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode_r <= PMW_RUN;
        else
            mode_r <= mode_nxt;
    end

    // status flags; on entry only these, the watchdog counter and the interrupt snapshot change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_flag_r <= 1'b0;
            timeout_flag_r <= 1'b0;
        end else begin
            if (halt_cmd)
                power_down_flag_r <= 1'b1;
            else if (clrwdt_cmd)
                power_down_flag_r <= 1'b0;
            if (in_lp && wdt_ovf)
                timeout_flag_r <= 1'b1;
            else if (halt_cmd)
                timeout_flag_r <= 1'b0;
        end
    end

    // watchdog counter, cleared by halt and clear watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdt_cnt_r <= '0;
        else if (halt_cmd || clrwdt_cmd || wdt_ovf)
            wdt_cnt_r <= '0;
        else if (osc_ctl_r[PMW_OSC_WDTEN])
            wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end

    // wake response pulses, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wake_ctl <= '0;
        else begin
            wake_ctl.cpu_run <= (mode_nxt == PMW_RUN);
            wake_ctl.full_reset <= in_lp & ext_rst_fall;
            wake_ctl.pc_sp_reset <= in_lp & wdt_ovf & ~ext_rst_fall;
            wake_ctl.irq_service <= in_lp & irq_wake & ~ext_rst_fall
                & ~wdt_ovf & irq_enabled & ~stack_full;
        end
    end

    // effective source flag; fast only once its oscillator is stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            on_sub_r <= 1'b1;
        else if (sysclk_select == PMW_CKS_SUB)
            on_sub_r <= 1'b1;
        else if (fast_ok)
            on_sub_r <= 1'b0;
    end

    // clock gating per mode, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_ctl <= '0;
            sys_div_sel <= DIV_SUB_SEL;
        end else begin
            clk_ctl.sys_clk_en <= (mode_nxt == PMW_RUN);
            clk_ctl.high_speed_clock_en <= (mode_nxt == PMW_IDLE1)
                | (mode_nxt == PMW_IDLE2) | (mode_nxt == PMW_WAKE)
                | ((mode_nxt == PMW_RUN)
                   & (sysclk_select != PMW_CKS_SUB));
            clk_ctl.low_speed_clock_en <= (mode_nxt == PMW_IDLE0)
                | (mode_nxt == PMW_IDLE1) | (mode_nxt == PMW_RUN)
                | (mode_nxt == PMW_WAKE);
            clk_ctl.watchdog_base_clock_en <= osc_ctl_r[PMW_OSC_WDTEN];
            clk_ctl.wdt_src_crystal <= low_freq_source_select;
            // one-hot divider select, top bit is both select 110 and the sub clock
            if (sysclk_select == PMW_CKS_SUB)
                sys_div_sel <= DIV_SUB_SEL;
            else if (fast_ok)
                sys_div_sel <= 7'(7'h01 << sysclk_select);
        end
    end

    // read mux
    always_comb begin
        prdata = '0;
        if (rd) begin
            unique case (paddr)
                PMW_SCC_OFF: prdata[7:0] = system_clock_control_r;
                PMW_WAKE_OFF: prdata[PMW_PA_W-1:0] = port_a_wake_enable_r;
                PMW_OSC_OFF: prdata[2:0] = osc_ctl_r;
                PMW_STAT_OFF: begin
                    prdata[PMW_ST_PDF] = power_down_flag_r;
                    prdata[PMW_ST_TO] = timeout_flag_r;
                    prdata[PMW_ST_INT_FAST_OSC_STABLE] = int_fast_osc_stable;
                    prdata[PMW_ST_EXT_FAST_OSC_STABLE] = ext_fast_osc_stable;
                    prdata[PMW_ST_SLOW] = on_sub_r;
                    prdata[PMW_ST_MODE+:3] = mode_r;
                end
                default: prdata = '0;
            endcase
        end
    end

    // checks
    a_halt_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        halt_cmd && !fast_osc_idle_enable && !slow_osc_idle_enable
        |=> mode_r == PMW_SLEEP) else $error("sleep not entered");
    a_halt_idle0: assert property (@(posedge pclk) disable iff (!presetn)
        halt_cmd && !fast_osc_idle_enable && slow_osc_idle_enable
        |=> mode_r == PMW_IDLE0 && !clk_ctl.high_speed_clock_en)
        else $error("idle0 wrong");
    a_halt_idle1: assert property (@(posedge pclk) disable iff (!presetn)
        halt_cmd && fast_osc_idle_enable && slow_osc_idle_enable
        |=> clk_ctl.high_speed_clock_en && clk_ctl.low_speed_clock_en)
        else $error("idle1 clocks off");
    a_halt_idle2: assert property (@(posedge pclk) disable iff (!presetn)
        halt_cmd && fast_osc_idle_enable && !slow_osc_idle_enable
        |=> !clk_ctl.low_speed_clock_en && !clk_ctl.sys_clk_en)
        else $error("idle2 wrong");
    a_halt_flags: assert property (@(posedge pclk) disable iff (!presetn)
        halt_cmd && !wdt_ovf |=> power_down_flag_r && !timeout_flag_r
        && wdt_cnt_r == '0) else $error("halt flags wrong");
    a_clrwdt_pdf: assert property (@(posedge pclk) disable iff (!presetn)
        clrwdt_cmd && !halt_cmd |=> !power_down_flag_r)
        else $error("pdf not cleared");
    a_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn)
        in_lp && wdt_ovf |=> timeout_flag_r && mode_r == PMW_WAKE)
        else $error("watchdog wake wrong");
    a_old_irq: assert property (@(posedge pclk) disable iff (!presetn)
        in_lp && !pa_fall && !wdt_ovf && !ext_rst_fall && irq_pend_at_halt_r
        |=> mode_r != PMW_WAKE) else $error("old irq woke");
    a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r == PMW_WAKE && sysclk_select != PMW_CKS_SUB && !fast_ok
        |=> mode_r == PMW_WAKE) else $error("ran before stable");
    a_slow_sel: assert property (@(posedge pclk) disable iff (!presetn)
        sysclk_select == PMW_CKS_SUB ##1 sysclk_select == PMW_CKS_SUB
        |-> sys_div_sel[PMW_DIV_W]) else $error("sub clock not used");

    // clock select checks
    a_div_hold: assert property (@(posedge pclk) disable iff (!presetn)
        sysclk_select != PMW_CKS_SUB && !fast_ok
        |=> $stable(sys_div_sel))
        else $error("switched before stable");

    a_div_fast: assert property (@(posedge pclk) disable iff (!presetn)
        sysclk_select != PMW_CKS_SUB && fast_ok
        |=> $onehot(sys_div_sel) && !on_sub_r)
        else $error("fast divider wrong");

    a_slow_status: assert property (@(posedge pclk) disable iff (!presetn)
        sysclk_select == PMW_CKS_SUB
        |=> on_sub_r && sys_div_sel == DIV_SUB_SEL)
        else $error("slow mode not shown");

    a_osc_settle: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(osc_ctl_r[PMW_OSC_IRCEN])
        |-> !int_fast_osc_stable)
        else $error("stable flag not low");

    // low power entry checks
    a_sleep_clocks: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r == PMW_SLEEP |-> !clk_ctl.high_speed_clock_en
        && !clk_ctl.low_speed_clock_en && !clk_ctl.sys_clk_en)
        else $error("clock left on in sleep");

    a_wdt_clock: assert property (@(posedge pclk) disable iff (!presetn)
        osc_ctl_r[PMW_OSC_WDTEN]
        |=> clk_ctl.watchdog_base_clock_en)
        else $error("watchdog clock off");

    a_halt_regs: assert property (@(posedge pclk) disable iff (!presetn)
        halt_cmd |=> $stable(system_clock_control_r)
        && $stable(port_a_wake_enable_r) && $stable(osc_ctl_r))
        else $error("halt changed registers");

    a_wdt_count: assert property (@(posedge pclk) disable iff (!presetn)
        osc_ctl_r[PMW_OSC_WDTEN] && !halt_cmd && !clrwdt_cmd && !wdt_ovf
        |=> wdt_cnt_r == $past(wdt_cnt_r) + 1'b1)
        else $error("watchdog not counting");

    a_wdt_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !osc_ctl_r[PMW_OSC_WDTEN]
        |=> $stable(wdt_cnt_r) || wdt_cnt_r == '0)
        else $error("watchdog ran disabled");

    a_halt_pdf: assert property (@(posedge pclk) disable iff (!presetn)
        halt_cmd
        |=> power_down_flag_r)
        else $error("pdf not set");

    // wake checks
    a_pa_wake: assert property (@(posedge pclk) disable iff (!presetn)
        in_lp && pa_fall
        |=> mode_r == PMW_WAKE)
        else $error("pin fall did not wake");

    a_rst_wake: assert property (@(posedge pclk) disable iff (!presetn)
        in_lp && ext_rst_fall
        |=> wake_ctl.full_reset && mode_r == PMW_WAKE)
        else $error("reset pin wake wrong");

    a_irq_serve: assert property (@(posedge pclk) disable iff (!presetn)
        in_lp && irq_wake && irq_enabled && !stack_full && !ext_rst_fall
        && !wdt_ovf |=> wake_ctl.irq_service)
        else $error("irq not serviced");

    a_irq_defer: assert property (@(posedge pclk) disable iff (!presetn)
        in_lp && irq_wake && (!irq_enabled || stack_full)
        |=> !wake_ctl.irq_service && mode_r == PMW_WAKE)
        else $error("irq wake not deferred");

endmodule // pmw_ctrl

// ### tb/pmw_core_model.sv
// core stand-in driving wake sources into the block
`timescale 1ns/1ps
module pmw_core_model
    import pmw_pkg::*;
(
    input wire logic pclk,
    input pmw_pkg::pmw_wake_t wake_ctl,
    output logic external_reset_pin_n,
    output logic [pmw_pkg::PMW_PA_W-1:0] port_a_in,
    output logic irq_req,
    output logic irq_enabled,
    output logic stack_full
);
    // idle levels: pins pulled high, no request
    initial begin
        external_reset_pin_n = 1'b1;
        port_a_in = '1;
        irq_req = 1'b0;
        irq_enabled = 1'b0;
        stack_full = 1'b0;
    end
    // a serviced request is taken, an unserviced one stays pending
    always @(posedge pclk) begin
        if (wake_ctl.irq_service === 1'b1) begin
            irq_req <= 1'b0;
        end
    end
    // raise or drop a request with its enable and stack state
    task automatic set_irq(input logic req, input logic en, input logic full);
        @(posedge pclk);
        irq_enabled <= en;
        stack_full <= full;
        irq_req <= req;
    endtask
    // low pulse on one port pin or the reset pin, then back high
    task automatic pin_fall(input int idx);
        @(posedge pclk);
        if (idx < 0) external_reset_pin_n <= 1'b0;
        else port_a_in[idx] <= 1'b0;
        repeat (3) @(posedge pclk);
        external_reset_pin_n <= 1'b1;
        port_a_in <= '1;
    endtask
endmodule // pmw_core_model

// ### tb/tb_pmw_ctrl.sv
// self-checking bench for the power mode and wake block
`timescale 1ns/1ps
module tb_pmw_ctrl import pmw_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic external_reset_pin_n;
    logic [PMW_PA_W-1:0] port_a_in;
    logic irq_req;
    logic irq_enabled;
    logic stack_full;
    pmw_clk_t clk_ctl;
    pmw_wake_t wake_ctl;
    logic [PMW_DIV_W:0] sys_div_sel;
    logic [31:0] rdat;
    logic rerr;
    logic [2:0] seen = 3'h0;
    int fails = 0;
    int checks = 0;
    pmw_mode_t mode_exp [4] = '{PMW_SLEEP, PMW_IDLE0, PMW_IDLE2, PMW_IDLE1};
    always #20 pclk = ~pclk;
    pmw_ctrl pmw_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_pin_n(external_reset_pin_n), .port_a_in(port_a_in),
        .irq_req(irq_req), .irq_enabled(irq_enabled),
        .stack_full(stack_full), .clk_ctl(clk_ctl), .wake_ctl(wake_ctl),
        .sys_div_sel(sys_div_sel));
    pmw_core_model pmw_core_model_inst (.pclk(pclk), .wake_ctl(wake_ctl),
        .external_reset_pin_n(external_reset_pin_n), .port_a_in(port_a_in),
        .irq_req(irq_req), .irq_enabled(irq_enabled),
        .stack_full(stack_full));
    // sticky capture of one-cycle wake pulses
    always @(posedge pclk) begin
        if (wake_ctl.full_reset === 1'b1) seen[2] <= 1'b1;
        if (wake_ctl.pc_sp_reset === 1'b1) seen[1] <= 1'b1;
        if (wake_ctl.irq_service === 1'b1) seen[0] <= 1'b1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            fails++;
            end_sim();
        end
    endtask
    // bounded wait for the core to be released
    task automatic wait_run();
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge pclk);
            if (wake_ctl.cpu_run === 1'b1) break;
        end
        if (n == 300) begin
            fails++;
            end_sim();
        end
    endtask
    // write clock control, halt, then check mode, flags and clock gating
    task automatic halt(input logic [7:0] system_clock_control);
        apb(1'b1, PMW_SCC_OFF, {24'h0, system_clock_control});
        apb(1'b1, PMW_CMD_OFF, 32'h1);
        repeat (2) @(posedge pclk);
        apb(1'b0, PMW_STAT_OFF, 32'h0);
        check(32'(rdat[7:5]), 32'(mode_exp[system_clock_control[1:0]]));
        check(32'(rdat[1:0]), 32'h1);
        check(32'(clk_ctl.high_speed_clock_en), 32'(system_clock_control[1]));
        check(32'(clk_ctl.low_speed_clock_en), 32'(system_clock_control[0]));
        check(32'(clk_ctl.sys_clk_en), 32'h0);
        check(32'(clk_ctl.watchdog_base_clock_en), 32'h1);
        check(32'(clk_ctl.wdt_src_crystal), 32'(system_clock_control[2]));
        seen = 3'h0;
    endtask
    initial begin
        int i;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(32'(sys_div_sel), 32'h40);
        apb(1'b0, PMW_SCC_OFF, 32'h0);
        check(rdat, 32'he0);
        apb(1'b0, PMW_STAT_OFF, 32'h0);
        check(rdat, 32'h10);
        apb(1'b0, 8'h20, 32'h0);
        check(32'(rerr), 32'h1);
        check(32'(pready), 32'h1);
        $display("reset and map test done");
        // leaving slow mode waits for the fast oscillator
        apb(1'b1, PMW_SCC_OFF, 32'h0);
        repeat (4) @(posedge pclk);
        check(32'(sys_div_sel), 32'h40);
        apb(1'b1, PMW_OSC_OFF, 32'h5);
        apb(1'b0, PMW_STAT_OFF, 32'h0);
        check(32'(rdat[PMW_ST_INT_FAST_OSC_STABLE]), 32'h0);
        for (i = 0; i < 100 && rdat[PMW_ST_INT_FAST_OSC_STABLE] !== 1'b1; i++) begin
            apb(1'b0, PMW_STAT_OFF, 32'h0);
        end
        check(32'(rdat[PMW_ST_INT_FAST_OSC_STABLE]), 32'h1);
        for (i = 0; i < 7; i++) begin
            apb(1'b1, PMW_SCC_OFF, 32'(i << PMW_CKS_LSB));
            repeat (4) @(posedge pclk);
            check(32'(sys_div_sel), 32'h1 << i);
            apb(1'b0, PMW_STAT_OFF, 32'h0);
            check(32'(rdat[PMW_ST_SLOW]), 32'h0);
        end
        $display("clock select test done");
        // every halt mode, woken by an enabled port pin
        apb(1'b1, PMW_WAKE_OFF, 32'h1);
        for (i = 0; i < 8; i++) begin
            halt(8'(i));
            if (i == 0) begin
                pmw_core_model_inst.pin_fall(1);
                repeat (4) @(posedge pclk);
                check(32'(wake_ctl.cpu_run), 32'h0);
            end
            pmw_core_model_inst.pin_fall(0);
            wait_run();
            check(32'(seen), 32'h0);
            apb(1'b0, PMW_SCC_OFF, 32'h0);
            check(rdat, 32'(i));
            apb(1'b1, PMW_CMD_OFF, 32'h2);
            apb(1'b0, PMW_STAT_OFF, 32'h0);
            check(32'(rdat[PMW_ST_PDF]), 32'h0);
        end
        $display("halt mode test done");
        // interrupt wakes: disabled, pending at halt, serviced, stack full
        halt(8'h0);
        pmw_core_model_inst.set_irq(1'b1, 1'b0, 1'b0);
        wait_run();
        check(32'(seen), 32'h0);
        halt(8'h3);
        repeat (10) @(posedge pclk);
        check(32'(wake_ctl.cpu_run), 32'h0);
        pmw_core_model_inst.set_irq(1'b0, 1'b1, 1'b0);
        pmw_core_model_inst.set_irq(1'b1, 1'b1, 1'b0);
        wait_run();
        check(32'(seen), 32'h1);
        halt(8'h3);
        pmw_core_model_inst.set_irq(1'b1, 1'b1, 1'b1);
        wait_run();
        check(32'(seen), 32'h0);
        pmw_core_model_inst.set_irq(1'b0, 1'b0, 1'b0);
        $display("interrupt wake test done");
        // reset pin wake gives a full reset
        halt(8'h0);
        pmw_core_model_inst.pin_fall(-1);
        wait_run();
        check(32'(seen[2]), 32'h1);
        $display("reset pin wake test done");
        end_sim();
    end
endmodule // tb_pmw_ctrl
